// ---- fbs_img_hold.sv ----
// One direction of the I/O image: live words plus a held view.
// Assumes writers on pclk; the view follows live unless held.
`timescale 1ns/100ps
module fbs_img_hold #(
    parameter int unsigned WORDS = 122 // Image size in words
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic wr_en, // Write strobe
    input wire logic [6:0] wr_word, // First word written
    input wire logic [31:0] wr_data, // Two-word data
    input wire logic [31:0] wr_mask, // Two-word bit mask
    input wire logic hold, // Freeze the view
    input wire logic take, // Refresh view while held
    input wire logic [6:0] rd_word, // First word read
    output logic [31:0] rd_data, // Two words of the view
    output logic [31:0] tap // Words 0 and 1 of the view
);
    typedef struct packed {
        logic [WORDS-1:0][15:0] live;
        logic [WORDS-1:0][15:0] view;
    } fbs_hold_st_t;
    fbs_hold_st_t st_ff, nxt_st;
    logic lo_ok, hi_ok;

    assign lo_ok = 32'(wr_word) < WORDS;
    assign hi_ok = 32'(wr_word) + 32'd1 < WORDS;

    // Masked write; a later write simply overwrites, no queue
    always_comb begin
        nxt_st = st_ff;
        if (wr_en && lo_ok) begin
            nxt_st.live[wr_word] = (st_ff.live[wr_word] & ~wr_mask[15:0])
                | (wr_data[15:0] & wr_mask[15:0]);
        end
        if (wr_en && hi_ok) begin
            nxt_st.live[wr_word + 7'h01] =
                (st_ff.live[wr_word + 7'h01] & ~wr_mask[31:16])
                | (wr_data[31:16] & wr_mask[31:16]);
        end
        if (!hold || take) begin
            nxt_st.view = st_ff.live;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read two adjacent words so any 16-bit span is reachable
    always_comb begin
        rd_data = '0;
        if (32'(rd_word) < WORDS) begin
            rd_data[15:0] = st_ff.view[rd_word];
        end
        if (32'(rd_word) + 32'd1 < WORDS) begin
            rd_data[31:16] = st_ff.view[rd_word + 7'h01];
        end
    end
    assign tap = {st_ff.view[1], st_ff.view[0]};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_view_held: assert property (
        hold && !take |=> $stable(st_ff.view))
        else $error("held view changed");
    chk_last_write: assert property (
        wr_en && wr_word == 7'h00 && wr_mask[15:0] == 16'hFFFF
        |=> st_ff.live[0] == $past(wr_data[15:0]))
        else $error("last write not kept");
endmodule

// ---- fbs_io_image.sv ----
// Top of the fieldbus slave I/O image access block.
// Assumes the fieldbus engine and flash logic run on pclk.
`timescale 1ns/100ps

// ****************************************
// Function
// ****************************************
// Function
// - Bit read returns one input bit
// - Bit write updates exactly one output bit
// - Byte read returns eight consecutive inputs
// - Byte write sets eight consecutive outputs
// - Word read returns sixteen consecutive inputs
// - Word write sets sixteen consecutive outputs
// - Repeated writes: only latest reaches master
// - Unlocked input reads may mix old, new
// - Multi-bit transfers use a flag interlock
// - Handshake word 2000, flag 2016, ack 2020
// - Wait flag, read, ack, wait low, clear
// - Active station number is readable
// - Stored flash station number is readable
// - SYNC flag sets on SYNC mode entry
// - FREEZE flag sets on FREEZE mode entry
// - FREEZE flag clears on UNFREEZE, stop, reset
// - Timeout clears flags only with watchdog
// - Signals numbered 2000 to 3951 per side
module fbs_io_image (
    input wire logic pclk, // APB clock, 250 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire fbs_pkg::fbs_img_wr_t mst_in_wr, // Input word write
    input wire logic [6:0] mst_out_word, // Output word to fetch
    output logic [15:0] mst_out_data, // Fetched output word
    input wire fbs_pkg::fbs_mst_ev_t mst_ev, // Master mode events
    input wire logic wdt_en, // Master watchdog enabled
    input wire logic [7:0] active_station_number, // In use
    input wire logic [7:0] stored_station_number, // From flash
    output logic sync_mode_flag, // SYNC mode
    output logic freeze_mode_flag, // FREEZE mode
    output logic master_write_done_flag, // Input 2016 view
    output logic robot_read_ack_flag // Output 2020 view
);
    import fbs_pkg::*;

    // ****************************************
    // State and decode types
    // ****************************************
    typedef struct packed {
        logic hs_en;
        logic [11:0] sig;
        logic [31:0] rdata;
        logic err;
        fbs_hs_state_t hs_st;
        logic [15:0] hs_data;
        logic [15:0] mst_data;
    } fbs_ctl_st_t;

    typedef struct packed {
        logic hit;
        logic rd_ok;
        logic wr_ok;
        logic img_in;
        logic img_out;
        fbs_acc_t acc;
    } fbs_dec_t;

    fbs_ctl_st_t st_ff, nxt_st;

    // Word and bit of a signal number
    function automatic fbs_pos_t sig_pos(input logic [11:0] s);
        logic [11:0] o;
        o = s - SIG_FIRST;
        sig_pos.word = o[WIDX_W+3:4];
        sig_pos.bitn = o[3:0];
    endfunction

    // Span must stay inside the numbered range
    function automatic logic span_ok(input logic [11:0] s,
                                     input fbs_acc_t a);
        logic [12:0] last;
        logic [15:0] m;
        m = acc_mask(a);
        last = {1'b0, s} + 13'($countones(m)) - 13'h0001;
        span_ok = (s >= SIG_FIRST) && (last <= {1'b0, SIG_LAST});
    endfunction

    // Register address decode
    function automatic fbs_dec_t decode(input logic [7:0] a);
        decode = '{hit: 1'b1, rd_ok: 1'b1, wr_ok: 1'b0,
                   img_in: 1'b0, img_out: 1'b0, acc: ACC_WORD};
        if (a == OFF_CTRL || a == OFF_SIG) begin
            decode.wr_ok = 1'b1;
        end else if (a == OFF_IN_BIT) begin
            decode.img_in = 1'b1;
            decode.acc = ACC_BIT;
        end else if (a == OFF_IN_BYTE) begin
            decode.img_in = 1'b1;
            decode.acc = ACC_BYTE;
        end else if (a == OFF_IN_WORD) begin
            decode.img_in = 1'b1;
        end else if (a == OFF_OUT_BIT) begin
            decode = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ACC_BIT};
        end else if (a == OFF_OUT_BYTE) begin
            decode = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ACC_BYTE};
        end else if (a == OFF_OUT_WORD) begin
            decode = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ACC_WORD};
        end else if (a == OFF_STATUS || a == OFF_STATION
                     || a == OFF_HS_DATA) begin
            decode.rd_ok = 1'b1;
        end else begin
            decode = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ACC_WORD};
        end
    endfunction

    // ****************************************
    // Bus phase and image paths
    // ****************************************
    fbs_dec_t dec;
    fbs_pos_t pos, ack_pos;
    logic setup, access, apb_err, apb_out_wr, hs_wr, out_we;
    logic [31:0] in_pair, in_tap, out_pair, out_tap;
    logic [31:0] in_val, out_wdata, out_wmask;
    logic [6:0] out_wword;
    logic [15:0] apb_lane, in_word;
    logic in_flag;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign dec = decode(paddr);
    assign pos = sig_pos(st_ff.sig);
    assign ack_pos = sig_pos(HS_ACK_SIG);

    // Refused: unmapped, wrong direction, or span off the end
    assign apb_err = !dec.hit || (pwrite ? !dec.wr_ok : !dec.rd_ok)
        || ((dec.img_in || dec.img_out)
            && !span_ok(st_ff.sig, dec.acc));

    // Input read taken from the view as it stands, no interlock
    assign in_val = in_pair >> pos.bitn;
    assign in_word = in_tap[HS_WORD_POS +: 16];
    assign in_flag = in_tap[HS_FLAG_POS];

    // Output write lands at the access edge only
    assign apb_out_wr = access & pwrite & dec.img_out & ~st_ff.err;
    assign hs_wr = (st_ff.hs_st == HS_ACK_SET
        || st_ff.hs_st == HS_ACK_CLR) & ~apb_out_wr;
    assign out_we = apb_out_wr | hs_wr;
    assign apb_lane = pwdata[15:0] & acc_mask(dec.acc);

    // Bus writes win the port; the handshake waits one cycle
    always_comb begin
        if (apb_out_wr) begin
            out_wword = pos.word;
            out_wdata = {16'h0000, apb_lane} << pos.bitn;
            out_wmask = {16'h0000, acc_mask(dec.acc)} << pos.bitn;
        end else begin
            out_wword = ack_pos.word;
            out_wdata = {31'h00000000, st_ff.hs_st == HS_ACK_SET}
                << ack_pos.bitn;
            out_wmask = 32'h00000001 << ack_pos.bitn;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.mst_data = out_pair[15:0];
        // Setup edge: read data and error ready for access phase
        if (setup) begin
            nxt_st.err = apb_err;
            nxt_st.rdata = '0;
            if (!pwrite && !apb_err) begin
                if (dec.img_in) begin
                    nxt_st.rdata = {16'h0000,
                        in_val[15:0] & acc_mask(dec.acc)};
                end else if (paddr == OFF_CTRL) begin
                    nxt_st.rdata[CTRL_HS_EN_BIT] = st_ff.hs_en;
                end else if (paddr == OFF_SIG) begin
                    nxt_st.rdata[11:0] = st_ff.sig;
                end else if (paddr == OFF_STATUS) begin
                    nxt_st.rdata[STAT_SYNC_BIT] = sync_mode_flag;
                    nxt_st.rdata[STAT_FREEZE_BIT] = freeze_mode_flag;
                    nxt_st.rdata[STAT_HS_LSB +: 2] = st_ff.hs_st;
                end else if (paddr == OFF_STATION) begin
                    nxt_st.rdata[7:0] = active_station_number;
                    nxt_st.rdata[STN_STORED_LSB +: 8] =
                        stored_station_number;
                end else if (paddr == OFF_HS_DATA) begin
                    nxt_st.rdata[15:0] = st_ff.hs_data;
                end
            end
        end
        // Access edge: register writes
        if (access && pwrite && !st_ff.err) begin
            if (paddr == OFF_CTRL) begin
                nxt_st.hs_en = pwdata[CTRL_HS_EN_BIT];
            end else if (paddr == OFF_SIG) begin
                nxt_st.sig = pwdata[11:0];
            end
        end
        // Robot side of the completion-flag interlock
        case (st_ff.hs_st)
            HS_IDLE: begin
                if (st_ff.hs_en && in_flag) begin
                    nxt_st.hs_data = in_word;
                    nxt_st.hs_st = HS_ACK_SET;
                end
            end
            HS_ACK_SET: begin
                if (hs_wr) begin
                    nxt_st.hs_st = HS_WAIT_LOW;
                end
            end
            HS_WAIT_LOW: begin
                if (!in_flag) begin
                    nxt_st.hs_st = HS_ACK_CLR;
                end
            end
            HS_ACK_CLR: begin
                if (hs_wr) begin
                    nxt_st.hs_st = HS_IDLE;
                end
            end
            default: nxt_st.hs_st = HS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{hs_en: CTRL_HS_EN_RST, sig: SIG_RST,
                       hs_st: HS_IDLE, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Images and mode flags
    // ****************************************
    // Input image: master writes, robot reads; FREEZE holds it
    fbs_img_hold #(.WORDS(IMG_WORDS)) u_in_img (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mst_in_wr.we),
        .wr_word(mst_in_wr.word),
        .wr_data({16'h0000, mst_in_wr.data}),
        .wr_mask(IN_WR_MASK),
        .hold(freeze_mode_flag),
        .take(mst_ev.freeze_req),
        .rd_word(pos.word),
        .rd_data(in_pair),
        .tap(in_tap)
    );

    // Output image: robot writes, master reads; SYNC holds it
    fbs_img_hold #(.WORDS(IMG_WORDS)) u_out_img (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(out_we),
        .wr_word(out_wword),
        .wr_data(out_wdata),
        .wr_mask(out_wmask),
        .hold(sync_mode_flag),
        .take(mst_ev.sync_req),
        .rd_word(mst_out_word),
        .rd_data(out_pair),
        .tap(out_tap)
    );

    fbs_mode_flag u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .set_req(mst_ev.sync_req),
        .clr_req(mst_ev.unsync_req),
        .comm_stop(mst_ev.comm_stop),
        .comm_timeout(mst_ev.comm_timeout),
        .wdt_en(wdt_en),
        .flag(sync_mode_flag)
    );

    fbs_mode_flag u_freeze (
        .pclk(pclk),
        .presetn(presetn),
        .set_req(mst_ev.freeze_req),
        .clr_req(mst_ev.unfreeze_req),
        .comm_stop(mst_ev.comm_stop),
        .comm_timeout(mst_ev.comm_timeout),
        .wdt_en(wdt_en),
        .flag(freeze_mode_flag)
    );

    // Outputs; zero wait states keep the bus simple
    assign pready = 1'b1;
    assign prdata = st_ff.rdata;
    assign pslverr = st_ff.err & access;
    assign mst_out_data = st_ff.mst_data;
    assign master_write_done_flag = in_flag;
    assign robot_read_ack_flag = out_tap[HS_ACK_POS];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_flag_seen;
        st_ff.hs_st == HS_IDLE && st_ff.hs_en && in_flag;
    endsequence
    sequence seq_captured;
        st_ff.hs_st == HS_ACK_SET && st_ff.hs_data == $past(in_word);
    endsequence

    chk_bit_read: assert property (
        setup && !pwrite && paddr == OFF_IN_BIT && !apb_err
        |=> prdata[31:1] == 31'h00000000 && prdata[0] == $past(in_val[0]))
        else $error("bit read not a single input bit");
    chk_byte_read: assert property (
        setup && !pwrite && paddr == OFF_IN_BYTE && !apb_err
        |=> prdata[31:8] == 24'h000000)
        else $error("byte read wider than 8 bits");
    chk_word_read: assert property (
        setup && !pwrite && paddr == OFF_IN_WORD && !apb_err
        |=> prdata[31:16] == 16'h0000)
        else $error("word read wider than 16 bits");
    chk_hs_capture: assert property (
        seq_flag_seen |=> seq_captured)
        else $error("handshake word not captured");
    chk_hs_wait_low: assert property (
        st_ff.hs_st == HS_WAIT_LOW && in_flag |=> st_ff.hs_st == HS_WAIT_LOW)
        else $error("ack cleared while master flag high");
    chk_range_err: assert property (
        setup && paddr == OFF_IN_WORD && st_ff.sig > SIG_LAST - 12'h00F
        |=> pslverr)
        else $error("out of range signal not refused");
endmodule

// ---- fbs_mode_flag.sv ----
// One SYNC or FREEZE mode flag, driven by master-side events.
// Assumes event inputs are one-cycle pulses on pclk.
`timescale 1ns/100ps
module fbs_mode_flag (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic set_req, // Mode request pulse
    input wire logic clr_req, // Mode release pulse
    input wire logic comm_stop, // Orderly stop of traffic
    input wire logic comm_timeout, // Watchdog expiry pulse
    input wire logic wdt_en, // Master enabled its watchdog
    output logic flag // Mode flag
);
    typedef struct packed {
        logic flag;
    } fbs_flag_st_t;
    fbs_flag_st_t st_ff, nxt_st;
    logic kill;

    // A timeout counts only with the watchdog enabled
    assign kill = comm_stop | (comm_timeout & wdt_en);

    // Request sets over release; stop and timeout win over both
    always_comb begin
        nxt_st = st_ff;
        if (clr_req) begin
            nxt_st.flag = 1'b0;
        end
        if (set_req) begin
            nxt_st.flag = 1'b1;
        end
        if (kill) begin
            nxt_st.flag = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flag = st_ff.flag;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_flag_sets: assert property (set_req && !kill |=> flag)
        else $error("mode flag did not set");
    chk_timeout_clears: assert property (
        flag && comm_timeout && wdt_en |=> !flag)
        else $error("timeout did not clear mode flag");
    chk_no_wdt_keeps: assert property (
        flag && !comm_stop && !clr_req && !wdt_en |=> flag)
        else $error("mode flag lost without watchdog");
    chk_release_clears: assert property (
        clr_req && !set_req |=> !flag)
        else $error("release did not clear mode flag");
endmodule

// ---- fbs_mst_model.sv ----
// Master station model: writes input words, runs the flag handshake.
// Assumes pclk timing and the block's input image write port.
`timescale 1ns/100ps
module fbs_mst_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic go, // Start pulse
    input wire logic hs, // Run handshake instead of a plain write
    input wire logic [6:0] word, // Word index below 122
    input wire logic [15:0] data, // Data word
    input wire logic ack, // Robot acknowledge view
    output fbs_pkg::fbs_img_wr_t wr, // Input image write
    output logic busy // Handshake in progress
);
    import fbs_pkg::*;
    logic [1:0] step_ff;
    assign busy = step_ff != 2'h0;
    // Data first, then the flag; flag drops only after ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_ff <= 2'h0;
            wr <= '0;
        end else begin
            wr.we <= 1'b0;
            case (step_ff)
                2'h0: if (go) begin
                    wr <= '{1'b1, hs ? 7'h00 : word, data};
                    step_ff <= hs ? 2'h1 : 2'h0;
                end
                2'h1: begin
                    wr <= '{1'b1, 7'h01, 16'h0001};
                    step_ff <= 2'h2;
                end
                2'h2: if (ack) begin
                    wr <= '{1'b1, 7'h01, 16'h0000};
                    step_ff <= 2'h3;
                end
                // Data word stays put until ack clears
                default: if (!ack) step_ff <= 2'h0;
            endcase
        end
    end
endmodule

// ---- fbs_pkg.sv ----
// Constants, types and helpers for the fieldbus slave I/O image block.
// Assumes one pclk domain and software access over APB.
package fbs_pkg;
    // ****************************************
    // Signal numbering and image size
    // ****************************************
    localparam logic [11:0] SIG_FIRST = 12'h7D0; // Lowest signal number
    localparam logic [11:0] SIG_LAST = 12'hF6F; // Highest signal number
    localparam int unsigned IMG_WORDS = 122; // Words per direction
    localparam int unsigned WIDX_W = 7; // Word index width
    localparam logic [31:0] IN_WR_MASK = 32'h0000FFFF; // Master word lane

    // Handshake signal numbers
    localparam logic [11:0] HS_WORD_SIG = 12'h7D0; // Data word
    localparam logic [11:0] HS_FLAG_SIG = 12'h7E0; // Master done flag
    localparam logic [11:0] HS_ACK_SIG = 12'h7E4; // Robot ack flag
    localparam int unsigned HS_WORD_POS = int'(HS_WORD_SIG - SIG_FIRST);
    localparam int unsigned HS_FLAG_POS = int'(HS_FLAG_SIG - SIG_FIRST);
    localparam int unsigned HS_ACK_POS = int'(HS_ACK_SIG - SIG_FIRST);

    // ****************************************
    // Register offsets, fields, reset values
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SIG = 8'h04;
    localparam logic [7:0] OFF_IN_BIT = 8'h08;
    localparam logic [7:0] OFF_IN_BYTE = 8'h0C;
    localparam logic [7:0] OFF_IN_WORD = 8'h10;
    localparam logic [7:0] OFF_OUT_BIT = 8'h14;
    localparam logic [7:0] OFF_OUT_BYTE = 8'h18;
    localparam logic [7:0] OFF_OUT_WORD = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_STATION = 8'h24;
    localparam logic [7:0] OFF_HS_DATA = 8'h28;
    localparam int unsigned CTRL_HS_EN_BIT = 0;
    localparam int unsigned STAT_SYNC_BIT = 0;
    localparam int unsigned STAT_FREEZE_BIT = 1;
    localparam int unsigned STAT_HS_LSB = 4;
    localparam int unsigned STN_STORED_LSB = 8;
    localparam logic [11:0] SIG_RST = 12'h7D0;
    localparam logic CTRL_HS_EN_RST = 1'b0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00, HS_ACK_SET = 2'b01,
        HS_WAIT_LOW = 2'b10, HS_ACK_CLR = 2'b11
    } fbs_hs_state_t;
    typedef enum logic [1:0] {
        ACC_BIT = 2'b00, ACC_BYTE = 2'b01, ACC_WORD = 2'b10
    } fbs_acc_t;
    typedef struct packed {
        logic sync_req;
        logic unsync_req;
        logic freeze_req;
        logic unfreeze_req;
        logic comm_stop;
        logic comm_timeout;
    } fbs_mst_ev_t;
    typedef struct packed {
        logic we;
        logic [WIDX_W-1:0] word;
        logic [15:0] data;
    } fbs_img_wr_t;
    typedef struct packed {
        logic [WIDX_W-1:0] word;
        logic [3:0] bitn;
    } fbs_pos_t;

    // Lane mask of one access width
    function automatic logic [15:0] acc_mask(input fbs_acc_t a);
        case (a)
            ACC_BIT: acc_mask = 16'h0001;
            ACC_BYTE: acc_mask = 16'h00FF;
            default: acc_mask = 16'hFFFF;
        endcase
    endfunction
endpackage

// ---- tb_fbs_io_image.sv ----
// Self-checking bench for the I/O image block over APB.
// Assumes the master model is the only writer of input words.
`timescale 1ns/100ps
module tb_fbs_io_image;
    import fbs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, act = 0, sto = 0;
    logic [31:0] pwdata = 0, q, d;
    logic pready, pslverr, sf, ff, wdf, ack, e, busy, seen = 0;
    logic go = 0, hs = 0, wdt = 0;
    logic [6:0] ow = 0, mw = 0;
    logic [15:0] od, md = 0, iimg [0:122], oimg [0:122];
    logic [15:0] ms [3] = '{16'h0001, 16'h00FF, 16'hFFFF};
    logic [5:0] evs [9] = '{6'h20, 6'h01, 6'h08, 6'h10, 6'h04,
        6'h28, 6'h02, 6'h20, 6'h01};
    logic [1:0] exs [9] = '{1, 1, 3, 2, 0, 3, 0, 1, 0};
    int ts [4] = '{2, 2, 1, 0};
    fbs_mst_ev_t ev = '0;
    fbs_img_wr_t wr;
    int errors = 0, checks_done = 0, w, k;
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (ack === 1'b1 && wdf === 1'b1) seen <= 1'b1;
    fbs_io_image fbs_io_image_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(q), .pslverr(pslverr),
        .mst_in_wr(wr), .mst_out_word(ow), .mst_out_data(od), .mst_ev(ev),
        .wdt_en(wdt), .active_station_number(act),
        .stored_station_number(sto), .sync_mode_flag(sf),
        .freeze_mode_flag(ff), .master_write_done_flag(wdf),
        .robot_read_ack_flag(ack));
    fbs_mst_model fbs_mst_model_i (.pclk(pclk), .presetn(presetn),
        .go(go), .hs(hs), .word(mw), .data(md), .ack(ack), .wr(wr),
        .busy(busy));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One APB transfer; read data and error left in q and e
    task automatic apb(input logic wt, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wt;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            summarize();
        end
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask
    // Expected span of inputs from signal 2000+16w+k
    function automatic logic [31:0] pick(input logic [15:0] m);
        logic [31:0] t;
        t = {iimg[w + 1], iimg[w]};
        return (t >> k) & {16'h0, m};
    endfunction
    task automatic put(input logic [15:0] m, input logic [15:0] v);
        logic [31:0] t;
        t = {oimg[w + 1], oimg[w]};
        t = (t & ~({16'h0, m} << k)) | ({16'h0, v & m} << k);
        {oimg[w + 1], oimg[w]} = t;
    endtask
    initial begin
        for (int i = 0; i < 123; i++) begin
            iimg[i] = 16'h0;
            oimg[i] = 16'h0;
        end
        k = $urandom(59629);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_STATUS, 0);
        chk(q, 0);
        apb(0, OFF_SIG, 0);
        chk(q, 32'h7D0);
        act <= $urandom;
        sto <= $urandom;
        @(posedge pclk);
        apb(0, OFF_STATION, 0);
        chk(q, {16'h0, sto, act});
        $display("reset and station test done");
        // Inputs at random word and bit offsets, spans cross words
        repeat (8) begin
            w = 2 + $urandom % 119;
            k = $urandom % 16;
            d = $urandom;
            iimg[w] = d[15:0];
            md <= d[15:0];
            mw <= w;
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            apb(1, OFF_SIG, 32'h7D0 + 16 * w + k);
            apb(0, OFF_IN_BIT, 0);
            chk(q, pick(16'h0001));
            apb(0, OFF_IN_BYTE, 0);
            chk(q, pick(16'h00FF));
            apb(0, OFF_IN_WORD, 0);
            chk(q, pick(16'hFFFF));
        end
        $display("input read test done");
        // Word written twice, then byte and bit over it
        repeat (8) begin
            w = 2 + $urandom % 119;
            k = $urandom % 16;
            apb(1, OFF_SIG, 32'h7D0 + 16 * w + k);
            foreach (ts[t]) begin
                d = $urandom;
                put(ms[ts[t]], d[15:0]);
                apb(1, OFF_OUT_BIT + 8'(4 * ts[t]), d);
            end
            for (int j = 0; j < 2; j++) begin
                ow <= w + j;
                repeat (3) @(posedge pclk);
                chk(od, oimg[w + j]);
            end
        end
        $display("output write test done");
        apb(1, OFF_SIG, 32'hF6F);
        apb(0, OFF_IN_BIT, 0);
        chk(e, 0);
        apb(0, OFF_IN_WORD, 0);
        chk(e, 1);
        $display("range test done");
        // Mode events, timeout once without and once with watchdog
        for (int i = 0; i < 9; i++) begin
            ev <= fbs_mst_ev_t'(evs[i]);
            wdt <= i == 8;
            @(posedge pclk);
            ev <= '0;
            apb(0, OFF_STATUS, 0);
            chk(q[1:0], exs[i]);
            chk({ff, sf}, exs[i]);
        end
        $display("mode flag test done");
        apb(1, OFF_SIG, 32'h7E0);
        apb(1, OFF_OUT_WORD, 0);
        apb(1, OFF_CTRL, 1);
        d = $urandom;
        md <= d[15:0];
        hs <= 1'b1;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 200) begin
            errors++;
            summarize();
        end
        repeat (4) @(posedge pclk);
        apb(0, OFF_HS_DATA, 0);
        chk(q, {16'h0, d[15:0]});
        chk({seen, ack}, 2'b10);
        $display("handshake test done");
        summarize();
    end
endmodule
